// *** rtl/mfi_cfg.svh ***
// Purpose: Offsets, field positions, reset values and counts of the
//          multi-function interrupt and time base block.
// Assumes: Byte wide register port with a five bit address.
// Notes:   Definitions only; included by bare name.
`ifndef MFI_CFG_SVH
`define MFI_CFG_SVH

// ============================================================
// Register offsets
`define MFI_A_INT_CTRL 5'h00
`define MFI_A_GRP_FLAG 5'h01
`define MFI_A_SRC_FLAG_LO 5'h02
`define MFI_A_SRC_FLAG_HI 5'h03
`define MFI_A_SRC_EN_LO 5'h04
`define MFI_A_SRC_EN_HI 5'h05
`define MFI_A_PSC_SEL 5'h06
`define MFI_A_TB_CTRL 5'h07
`define MFI_A_UPPER_LO 5'h08
`define MFI_A_UPPER_HI 5'h09
`define MFI_A_LOWER_LO 5'h0A
`define MFI_A_LOWER_HI 5'h0B
`define MFI_A_CONV_CTRL2 5'h0C
`define MFI_A_HALL_EDGE 5'h0D
`define MFI_A_RESULT_LO 5'h0E
`define MFI_A_RESULT_HI 5'h0F

// ============================================================
// Field positions
`define MFI_B_GIE 0
`define MFI_B_GEN_LSB 1
`define MFI_B_TBE 6
`define MFI_B_TBF 5
`define MFI_B_TIMEBASE_RUN 7
`define MFI_B_UPPER_EN 1
`define MFI_B_LOWER_EN 0

// ============================================================
// Source flag positions inside the fifteen bit source vector
`define MFI_N_SRC 15
`define MFI_N_GRP 5
`define MFI_S_HALL 0
`define MFI_S_CDONE 3
`define MFI_S_CLIM 4
`define MFI_S_PWMP 5
`define MFI_S_PWMD 6
`define MFI_S_CAPO 9
`define MFI_S_CAPC 10
`define MFI_S_PTMP 11
`define MFI_S_PTMA 13

// Group membership masks over the source vector
`define MFI_M_GRP0 15'h0007
`define MFI_M_GRP1 15'h0018
`define MFI_M_GRP2 15'h01E0
`define MFI_M_GRP3 15'h0600
`define MFI_M_GRP4 15'h7800

// ============================================================
// Reset values and timing counts
`define MFI_RST_BYTE 8'h00
`define MFI_RST_SRC 15'h0000
`define MFI_PSC_DIV4 2'h3
`define MFI_TB_CNT_W 15
`define MFI_TB_FULL 15'h7FFF
`define MFI_TB_SEL_MAX 3'h7

`endif

// *** rtl/mfi_pkg.sv ***
// Purpose: Types used by the interrupt module; the time base module does not import them.
// Assumes: Nothing beyond the config header.
// Notes:   Vector codes follow declaration order.
`default_nettype none

// ============================================================
// Package
package mfi_pkg;
	// Vector targets; code 7 is never produced
	typedef enum logic [2:0] {
		MFI_VEC_GRP0,
		MFI_VEC_GRP1,
		MFI_VEC_GRP2,
		MFI_VEC_GRP3,
		MFI_VEC_GRP4,
		MFI_VEC_TB,
		MFI_VEC_NONE
	} mfi_vec_t;
	// One register byte
	typedef logic [7:0] mfi_byte_t;
endpackage : mfi_pkg

`default_nettype wire

// *** rtl/mfi_tb_if.sv ***
// Purpose: Carries time base controls and its overflow event.
// Assumes: Both ends on the same clock.
// Notes:   overflow is a one cycle pulse.
`default_nettype none

// ============================================================
// Interface
interface mfi_tb_if;
	logic run;               // Divider enabled
	logic [2:0] period_sel;  // Rollover bit choice
	logic [1:0] src_sel;     // Prescaler clock choice
	logic overflow;          // One cycle per time-out
	modport ctrl (output run, output period_sel, output src_sel,
		input overflow);
	modport unit (input run, input period_sel, input src_sel,
		output overflow);
endinterface : mfi_tb_if

`default_nettype wire

// *** rtl/mfi_timebase.sv ***
// Purpose: Prescaler and power-of-two divider of the time base.
// Assumes: sub_clk is a slow clock sampled as a synchronous level.
// Notes:   Counter clears while stopped so each start is clean.
`include "mfi_cfg.svh"
`default_nettype none

module mfi_timebase (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sub_clk,
	mfi_tb_if.unit tb
);
	// ============================================================
	// State
	logic [1:0] div4_cnt;                 // Divide-by-four phase
	logic sub_prev;                       // Last sampled slow clock
	logic tick;                           // Prescaler clock enable
	logic [`MFI_TB_CNT_W-1:0] cnt;        // Free running divider

	// True when the low (8 + sel) bits are all ones
	function automatic logic rolls(input logic [`MFI_TB_CNT_W-1:0] c,
		input logic [2:0] sel);
		logic [`MFI_TB_CNT_W-1:0] m;
		m = `MFI_TB_FULL >> (`MFI_TB_SEL_MAX - sel);
		return (c & m) == m;
	endfunction : rolls

	// ============================================================
	// Prescaler
	// Phase counter for the quarter rate option
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div4_cnt <= 2'h0;
		end else begin
			div4_cnt <= div4_cnt + 2'h1;
		end
	end

	// Slow clock history for its rising edge
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sub_prev <= 1'b0;
		end else begin
			sub_prev <= sub_clk;
		end
	end

	// Source choice: full rate, quarter rate, slow clock
	always_comb begin
		if (tb.src_sel == 2'b00) begin
			tick = 1'b1;
		end else if (tb.src_sel == 2'b01) begin
			tick = (div4_cnt == `MFI_PSC_DIV4);
		end else begin
			tick = sub_clk & ~sub_prev;
		end
	end

	// ============================================================
	// Divider
	// Counts prescaler ticks only while running
	always_ff @(posedge clk) begin
		if (!rst_n || !tb.run) begin
			cnt <= '0;
		end else if (tick) begin
			cnt <= cnt + 15'h0001;
		end
	end

	// Time-out after 2^(8+sel) ticks
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tb.overflow <= 1'b0;
		end else begin
			tb.overflow <= tb.run & tick & rolls(cnt, tb.period_sel);
		end
	end

	// ============================================================
	// Checks
	tb_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		!tb.run |=> (cnt == '0) && !tb.overflow)
		else $error("divider ran while stopped");

	// Only quarter rate ticks count, so a source switch cannot trip it
	div4_a: assert property (@(posedge clk) disable iff (!rst_n)
		(tb.src_sel == 2'b01 && tick)
		|=> (!(tb.src_sel == 2'b01 && tick)) [*3])
		else $error("quarter rate tick too often");

	min_period_a: assert property (@(posedge clk) disable iff (!rst_n)
		(tb.run && tick && tb.period_sel == 3'h0 && cnt[7:0] == 8'hFF
		&& $stable(tb.run)) |=> tb.overflow)
		else $error("time-out missing at 2^8");

endmodule : mfi_timebase

`default_nettype wire

// *** rtl/mfi_irq_top.sv ***
// Purpose: Multi-function interrupt grouping, vectoring and time base.
// Assumes: Source events are one cycle pulses synchronous to REF_CLK.
// Notes:   Core acknowledges the vector shown while VEC_REQ is high.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`include "mfi_cfg.svh"
`default_nettype none

module mfi_irq_top #(
	parameter int RES_W = 12 // Converter result width
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic [4:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic SUB_CLK,
	input wire logic [2:0] HALL_FILT,
	input wire logic CONV_DONE,
	input wire logic [RES_W-1:0] CONV_RESULT,
	input wire logic PWM_PERIOD,
	input wire logic [2:0] PWM_DUTY,
	input wire logic CAP_OVF,
	input wire logic CAP_CMP,
	input wire logic [1:0] PTM_P,
	input wire logic [1:0] PTM_A,
	input wire logic STACK_FULL,
	input wire logic VEC_ACK,
	input wire logic RETI,
	output logic VEC_REQ,
	output logic [2:0] VEC_ID,
	output logic WAKE
);
	// ============================================================
	// Register state
	logic global_irq_enable;              // Master enable
	logic [`MFI_N_GRP-1:0] group_enable;  // Per group enables
	logic timebase_irq_enable;            // Time base enable
	logic [`MFI_N_GRP-1:0] group_request_flag;
	logic timebase_flag;
	logic [`MFI_N_SRC-1:0] src_flag;      // All source flags
	logic [`MFI_N_SRC-1:0] src_en;        // All source enables
	logic [1:0] prescaler_source_sel;
	logic timebase_run;
	logic [2:0] timebase_period_sel;
	logic [RES_W-1:0] upper_bound;        // High boundary pair
	logic [RES_W-1:0] lower_bound;        // Low boundary pair
	logic [RES_W-1:0] conv_result;        // Last converted value
	logic upper_limit_trigger_enable;
	logic lower_limit_trigger_enable;
	logic [5:0] hall_edge_sel;            // Rise/fall per channel
	logic [2:0] hall_prev;                // Last hall levels

	// ============================================================
	// Combinational next values
	logic [2:0] hall_evt;
	logic limit_hit;
	logic [`MFI_N_SRC-1:0] src_set;
	logic [`MFI_N_SRC-1:0] src_clr;
	logic [`MFI_N_SRC-1:0] src_new;       // Flags becoming set
	logic [`MFI_N_GRP-1:0] grp_set;
	logic [`MFI_N_GRP-1:0] grp_clr;
	logic [`MFI_N_GRP-1:0] pend;
	logic tb_pend;
	logic tb_clr;
	logic svc;                            // Core takes the vector
	logic next_gie;
	logic next_req;
	mfi_pkg::mfi_vec_t next_vec;

	// Time base link
	mfi_tb_if tb_link ();

	// ============================================================
	// Helpers
	// Membership mask of one group
	function automatic logic [`MFI_N_SRC-1:0] grp_mask(input int g);
		logic [`MFI_N_SRC-1:0] m;
		m = '0;
		unique case (g)
			0: m = `MFI_M_GRP0;
			1: m = `MFI_M_GRP1;
			2: m = `MFI_M_GRP2;
			3: m = `MFI_M_GRP3;
			4: m = `MFI_M_GRP4;
			default: m = '0;
		endcase
		return m;
	endfunction : grp_mask

	// Upper byte of a value padded to sixteen bits
	function automatic mfi_pkg::mfi_byte_t hi_byte(
		input logic [RES_W-1:0] v);
		logic [15:0] w;
		w = 16'(v);
		return w[15:8];
	endfunction : hi_byte

	// Fixed priority: lowest group first, time base last
	function automatic mfi_pkg::mfi_vec_t pick(
		input logic [`MFI_N_GRP-1:0] p, input logic t);
		mfi_pkg::mfi_vec_t v;
		v = t ? mfi_pkg::MFI_VEC_TB : mfi_pkg::MFI_VEC_NONE;
		for (int i = `MFI_N_GRP - 1; i >= 0; i--) begin
			if (p[i]) begin
				v = mfi_pkg::mfi_vec_t'(3'(i));
			end
		end
		return v;
	endfunction : pick

	// ============================================================
	// Time base unit
	mfi_timebase u_timebase (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.sub_clk(SUB_CLK),
		.tb(tb_link.unit)
	);

	// Controls steer the divider directly from registers
	assign tb_link.run = timebase_run;
	assign tb_link.period_sel = timebase_period_sel;
	assign tb_link.src_sel = prescaler_source_sel;

	// ============================================================
	// Source events
	// Hall transitions of the chosen edge kind; 00 disables
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			hall_evt[i] = (HALL_FILT[i] & ~hall_prev[i]
				& hall_edge_sel[2*i])
				| (~HALL_FILT[i] & hall_prev[i]
				& hall_edge_sel[2*i+1]);
		end
	end

	// Limit compare on the value that just finished converting
	always_comb begin
		limit_hit = (upper_limit_trigger_enable
			&& CONV_RESULT > upper_bound)
			|| (lower_limit_trigger_enable
			&& CONV_RESULT < lower_bound);
	end

	// Gather every source into one vector
	always_comb begin
		src_set = '0;
		src_set[`MFI_S_HALL +: 3] = hall_evt;
		src_set[`MFI_S_CDONE] = CONV_DONE;
		src_set[`MFI_S_CLIM] = CONV_DONE & limit_hit;
		src_set[`MFI_S_PWMP] = PWM_PERIOD;
		src_set[`MFI_S_PWMD +: 3] = PWM_DUTY;
		src_set[`MFI_S_CAPO] = CAP_OVF;
		src_set[`MFI_S_CAPC] = CAP_CMP;
		src_set[`MFI_S_PTMP +: 2] = PTM_P;
		src_set[`MFI_S_PTMA +: 2] = PTM_A;
	end

	// Software clears by writing zero; a one leaves the flag alone
	always_comb begin
		src_clr = '0;
		if (WR && ADDR == `MFI_A_SRC_FLAG_LO) begin
			src_clr[7:0] = ~WDATA;
		end
		if (WR && ADDR == `MFI_A_SRC_FLAG_HI) begin
			src_clr[14:8] = ~WDATA[6:0];
		end
		src_new = src_set & ~src_flag;
	end

	// Group raise: an enabled member flag becomes set
	always_comb begin
		svc = VEC_ACK & VEC_REQ;
		grp_clr = '0;
		tb_clr = 1'b0;
		for (int g = 0; g < `MFI_N_GRP; g++) begin
			grp_set[g] = |(src_new & src_en & grp_mask(g));
			if (svc && VEC_ID == 3'(g)) begin
				grp_clr[g] = 1'b1;
			end
		end
		if (svc && VEC_ID == 3'(mfi_pkg::MFI_VEC_TB)) begin
			tb_clr = 1'b1;
		end
		if (WR && ADDR == `MFI_A_GRP_FLAG) begin
			grp_clr = grp_clr | ~WDATA[`MFI_N_GRP-1:0];
			tb_clr = tb_clr | ~WDATA[`MFI_B_TBF];
		end
	end

	// Vector selection and request gating
	always_comb begin
		pend = group_request_flag & group_enable;
		tb_pend = timebase_flag & timebase_irq_enable;
		next_vec = pick(pend, tb_pend);
		next_req = global_irq_enable & ~svc & ~STACK_FULL
			& (|pend | tb_pend);
		if (svc) begin
			next_gie = 1'b0;
		end else if (RETI) begin
			next_gie = 1'b1;
		end else if (WR && ADDR == `MFI_A_INT_CTRL) begin
			next_gie = WDATA[`MFI_B_GIE];
		end else begin
			next_gie = global_irq_enable;
		end
	end

	// ============================================================
	// Flags
	// Source flags survive service; only software clears them
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			src_flag <= `MFI_RST_SRC;
		end else begin
			src_flag <= (src_flag & ~src_clr) | src_set;
		end
	end

	// Group flags: set beats any clear in the same cycle
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			group_request_flag <= '0;
		end else begin
			group_request_flag <= (group_request_flag & ~grp_clr)
				| grp_set;
		end
	end

	// Time base flag follows every divider overflow
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			timebase_flag <= 1'b0;
		end else begin
			timebase_flag <= (timebase_flag & ~tb_clr)
				| tb_link.overflow;
		end
	end

	// Wake-up on any flag rising, enabled or not
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			WAKE <= 1'b0;
		end else begin
			WAKE <= |src_new | |(grp_set & ~group_request_flag)
				| (tb_link.overflow & ~timebase_flag);
		end
	end

	// ============================================================
	// Vectoring
	// Request and target are registered so the core sees stable pins
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			VEC_REQ <= 1'b0;
			VEC_ID <= 3'(mfi_pkg::MFI_VEC_NONE);
			global_irq_enable <= 1'b0;
		end else begin
			VEC_REQ <= next_req;
			VEC_ID <= 3'(next_vec);
			global_irq_enable <= next_gie;
		end
	end

	// ============================================================
	// Register writes
	// Control and configuration registers
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			group_enable <= '0;
			timebase_irq_enable <= 1'b0;
			src_en <= `MFI_RST_SRC;
			prescaler_source_sel <= 2'h0;
			timebase_run <= 1'b0;
			timebase_period_sel <= 3'h0;
			upper_limit_trigger_enable <= 1'b0;
			lower_limit_trigger_enable <= 1'b0;
			hall_edge_sel <= 6'h00;
		end else if (WR) begin
			unique case (ADDR)
				`MFI_A_INT_CTRL: begin
					group_enable <= WDATA[`MFI_B_GEN_LSB +: `MFI_N_GRP];
					timebase_irq_enable <= WDATA[`MFI_B_TBE];
				end
				`MFI_A_SRC_EN_LO: src_en[7:0] <= WDATA;
				`MFI_A_SRC_EN_HI: src_en[14:8] <= WDATA[6:0];
				`MFI_A_PSC_SEL: prescaler_source_sel <= WDATA[1:0];
				`MFI_A_TB_CTRL: begin
					timebase_run <= WDATA[`MFI_B_TIMEBASE_RUN];
					timebase_period_sel <= WDATA[2:0];
				end
				`MFI_A_CONV_CTRL2: begin
					upper_limit_trigger_enable <= WDATA[`MFI_B_UPPER_EN];
					lower_limit_trigger_enable <= WDATA[`MFI_B_LOWER_EN];
				end
				`MFI_A_HALL_EDGE: hall_edge_sel <= WDATA[5:0];
				default: ; // Other addresses hold no control state
			endcase
		end
	end

	// Boundary pairs, low byte then high byte
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			upper_bound <= '0;
			lower_bound <= '0;
		end else if (WR) begin
			if (ADDR == `MFI_A_UPPER_LO) upper_bound[7:0] <= WDATA;
			if (ADDR == `MFI_A_UPPER_HI) begin
				upper_bound[RES_W-1:8] <= WDATA[RES_W-9:0];
			end
			if (ADDR == `MFI_A_LOWER_LO) lower_bound[7:0] <= WDATA;
			if (ADDR == `MFI_A_LOWER_HI) begin
				lower_bound[RES_W-1:8] <= WDATA[RES_W-9:0];
			end
		end
	end

	// Result capture and hall history
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			conv_result <= '0;
			hall_prev <= 3'h0;
		end else begin
			if (CONV_DONE) conv_result <= CONV_RESULT;
			hall_prev <= HALL_FILT;
		end
	end

	// ============================================================
	// Read port
	// Data stands only in the cycle after the strobe; else zero
	always_ff @(posedge REF_CLK) begin
		if (!RST_N || !RD) begin
			RDATA <= `MFI_RST_BYTE;
		end else begin
			unique case (ADDR)
				`MFI_A_INT_CTRL: RDATA <= {1'b0, timebase_irq_enable,
					group_enable, global_irq_enable};
				`MFI_A_GRP_FLAG: RDATA <= {2'b00, timebase_flag,
					group_request_flag};
				`MFI_A_SRC_FLAG_LO: RDATA <= src_flag[7:0];
				`MFI_A_SRC_FLAG_HI: RDATA <= {1'b0, src_flag[14:8]};
				`MFI_A_SRC_EN_LO: RDATA <= src_en[7:0];
				`MFI_A_SRC_EN_HI: RDATA <= {1'b0, src_en[14:8]};
				`MFI_A_PSC_SEL: RDATA <= {6'h00, prescaler_source_sel};
				`MFI_A_TB_CTRL: RDATA <= {timebase_run, 4'h0,
					timebase_period_sel};
				`MFI_A_UPPER_LO: RDATA <= upper_bound[7:0];
				`MFI_A_UPPER_HI: RDATA <= hi_byte(upper_bound);
				`MFI_A_LOWER_LO: RDATA <= lower_bound[7:0];
				`MFI_A_LOWER_HI: RDATA <= hi_byte(lower_bound);
				`MFI_A_CONV_CTRL2: RDATA <= {6'h00,
					upper_limit_trigger_enable, lower_limit_trigger_enable};
				`MFI_A_HALL_EDGE: RDATA <= {2'b00, hall_edge_sel};
				`MFI_A_RESULT_LO: RDATA <= conv_result[7:0];
				`MFI_A_RESULT_HI: RDATA <= hi_byte(conv_result);
				default: RDATA <= `MFI_RST_BYTE; // Unmapped reads zero
			endcase
		end
	end

	// ============================================================
	// Checks
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	// Service step followed by the cleared state
	sequence svc_s;
		VEC_ACK && VEC_REQ;
	endsequence
	sequence quiet_s;
		!global_irq_enable && !VEC_REQ;
	endsequence

	grp_raise_a: assert property (
		(PWM_PERIOD && src_en[`MFI_S_PWMP] && !src_flag[`MFI_S_PWMP])
		|=> group_request_flag[2])
		else $error("group flag not raised");

	vec_gate_a: assert property (
		VEC_REQ |-> $past(global_irq_enable) && !$past(STACK_FULL))
		else $error("vector without enable or stack room");

	svc_clear_a: assert property (svc_s |=> quiet_s)
		else $error("service left global enable set");

	tb_svc_a: assert property (
		(svc_s and (VEC_ID == 3'(mfi_pkg::MFI_VEC_TB)
		&& !tb_link.overflow)) |=> !timebase_flag)
		else $error("time base flag not cleared");

	limit_a: assert property (
		(CONV_DONE && upper_limit_trigger_enable
		&& CONV_RESULT > upper_bound) |=> src_flag[`MFI_S_CLIM])
		else $error("limit flag missed");

	pwm_vec_a: assert property (
		(VEC_REQ && VEC_ID == 3'(mfi_pkg::MFI_VEC_GRP2))
		|-> $past(group_enable[2]) && $past(group_request_flag[2]))
		else $error("group two vector without enable");

	wake_rise_a: assert property ($rose(timebase_flag) |-> WAKE)
		else $error("no wake-up on flag rise");

	set_wins_a: assert property (
		(WR && ADDR == `MFI_A_SRC_FLAG_HI && !WDATA[`MFI_S_CAPO-8]
		&& CAP_OVF) |=> src_flag[`MFI_S_CAPO])
		else $error("clear beat hardware set");

endmodule : mfi_irq_top

`default_nettype wire

// *** dv/mfi_core_model.sv ***
// Purpose: Core side that takes vectors from the interrupt block.
// Assumes: go lets the bench hold the core off to answer slowly.
// Notes:   Returns from service are pulsed by the bench.
`default_nettype none

// ============================================================
// Core model
module mfi_core_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic vec_req,
	input wire logic [2:0] vec_id,
	output logic vec_ack,
	output logic [2:0] last_id,
	output int n_ack
);
	timeunit 1ns;
	timeprecision 1ns;
	// Ack drops after one cycle so a held request is never taken twice
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vec_ack <= 1'b0;
			last_id <= 3'h6;
			n_ack <= 0;
		end else if (go && vec_req && !vec_ack) begin
			vec_ack <= 1'b1;
			last_id <= vec_id;
			n_ack <= n_ack + 1;
		end else begin
			vec_ack <= 1'b0;
		end
	end
endmodule : mfi_core_model

`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench of the interrupt and time base block.
// Assumes: The bench plays software; the core model takes vectors.
// Notes:   Time base periods are measured from the starting write.
`default_nettype none

// ============================================================
// Bench
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sub = 1'b0;
	logic full = 1'b0, reti = 1'b0, go = 1'b1, req, ack, wake;
	logic [4:0] addr = 5'h00;
	logic [7:0] wdata = 8'h00, rdata;
	logic [14:0] src = 15'h0000;
	logic [2:0] hall = 3'h0, vid, last_id;
	logic [11:0] res = 12'h000;
	int n_mismatch = 0, cmp_count = 0, n_ack, n_wake = 0, cyc = 0;

	always #50 clk = ~clk;
	// Slow clock at a tenth of the system rate
	always #500 sub = ~sub;

	mfi_irq_top dut_u (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SUB_CLK(sub),
		.HALL_FILT(hall), .CONV_DONE(src[3]), .CONV_RESULT(res),
		.PWM_PERIOD(src[5]), .PWM_DUTY(src[8:6]), .CAP_OVF(src[9]),
		.CAP_CMP(src[10]), .PTM_P(src[12:11]), .PTM_A(src[14:13]),
		.STACK_FULL(full), .VEC_ACK(ack), .RETI(reti), .VEC_REQ(req),
		.VEC_ID(vid), .WAKE(wake));
	mfi_core_model core_u (.clk(clk), .rst_n(rst_n), .go(go),
		.vec_req(req), .vec_id(vid), .vec_ack(ack), .last_id(last_id),
		.n_ack(n_ack));

	// Wake pulses are counted mid-cycle, where the pin has settled
	always @(negedge clk) begin
		cyc++;
		if (wake === 1'b1)
			n_wake++;
		if (cyc == 30000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask : chk

	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : rd_reg

	task automatic rchk(input logic [4:0] a, input logic [7:0] e,
		input string nm);
		logic [7:0] d;
		rd_reg(a, d);
		chk(nm, {8'h00, e}, {8'h00, d});
	endtask : rchk

	task automatic src_chk(input logic [15:0] e);
		logic [7:0] lo, hi;
		rd_reg(5'h02, lo);
		rd_reg(5'h03, hi);
		chk("source flags", e, {hi, lo});
		wr_reg(5'h02, 8'h00);
		wr_reg(5'h03, 8'h00);
	endtask : src_chk

	// Hall bits toggle the filtered level, the rest are pulses
	task automatic pulse(input logic [14:0] m);
		@(posedge clk);
		src <= m & 15'h7FF8;
		hall <= hall ^ m[2:0];
		@(posedge clk);
		src <= 15'h0000;
	endtask : pulse

	task automatic ret_pulse();
		@(posedge clk);
		reti <= 1'b1;
		@(posedge clk);
		reti <= 1'b0;
	endtask : ret_pulse

	task automatic wait_ack(input int n0);
		int k;
		k = 0;
		while (n_ack == n0 && k < 60) begin
			@(negedge clk);
			k++;
		end
	endtask : wait_ack

	function automatic logic [2:0] grp_of(input int i);
		return i < 3 ? 3'h0 : i < 5 ? 3'h1 : i < 9 ? 3'h2 : i < 11 ? 3'h3
			: 3'h4;
	endfunction : grp_of

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	initial begin
		int i, n0, w0, k, sel, t, n, p;
		void'($urandom(68));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rchk(5'h06, 8'h00, "prescaler reset");
		rchk(5'h07, 8'h00, "time base reset");
		wr_reg(5'h06, 8'hFF);
		rchk(5'h06, 8'h03, "prescaler bits");
		wr_reg(5'h07, 8'hFF);
		rchk(5'h07, 8'h87, "time base bits");
		wr_reg(5'h07, 8'h00);
		rchk(5'h1F, 8'h00, "unmapped");
		$display("register test done");
		// Every source enabled, hall on both edges
		wr_reg(5'h0D, 8'h3F);
		wr_reg(5'h04, 8'hFF);
		wr_reg(5'h05, 8'h7F);
		wr_reg(5'h00, 8'h7F);
		repeat (10) begin
			i = $urandom_range(14, 0);
			if (i == 4)
				i = 3;
			n0 = n_ack;
			w0 = n_wake;
			pulse(15'h0001 << i);
			wait_ack(n0);
			chk("vector id", {13'h0000, grp_of(i)},
				{13'h0000, last_id});
			chk("wake count", 16'(w0 + 1), 16'(n_wake));
			rchk(5'h01, 8'h00, "group flag");
			rchk(5'h00, 8'h7E, "global enable");
			src_chk(16'h0001 << i);
			ret_pulse();
		end
		$display("source test done");
		// Core stack full, then two groups in priority order
		full <= 1'b1;
		n0 = n_ack;
		pulse(15'h0201);
		repeat (6) @(posedge clk);
		chk("held by stack", 16'(n0), 16'(n_ack));
		full <= 1'b0;
		wait_ack(n0);
		chk("first vector", 16'h0000, {13'h0000, last_id});
		ret_pulse();
		wait_ack(n0 + 1);
		chk("second vector", 16'h0003, {13'h0000, last_id});
		src_chk(16'h0201);
		$display("stack test done");
		// Limit compare with vectoring off
		wr_reg(5'h00, 8'h00);
		wr_reg(5'h08, 8'h10);
		wr_reg(5'h09, 8'h00);
		wr_reg(5'h0A, 8'h08);
		for (k = 0; k < 3; k++) begin
			wr_reg(5'h0C, k == 2 ? 8'h01 : 8'h02);
			res <= k == 0 ? 12'h011 + 12'($urandom_range(99)) :
				k == 1 ? 12'h010 : 12'h007;
			pulse(15'h0008);
			src_chk(k == 1 ? 16'h0008 : 16'h0018);
		end
		// Rising edges on hall A, falling on B, C switched off
		wr_reg(5'h0D, 8'h09);
		pulse(15'h0007);
		pulse(15'h0007);
		src_chk(16'h0003);
		// Software clear and capture overflow in the same cycle
		fork
			pulse(15'h0200);
			wr_reg(5'h03, 8'h00);
		join
		src_chk(16'h0200);
		wr_reg(5'h01, 8'h00);
		wr_reg(5'h00, 8'h41);
		$display("limit test done");
		// Time base for each prescaler source
		for (k = 0; k < 3; k++) begin
			sel = k == 0 ? $urandom_range(2, 0) : 0;
			p = k == 0 ? 1 : k == 1 ? 4 : 10;
			t = (1 << (8 + sel)) * p;
			n0 = n_ack;
			wr_reg(5'h06, 8'(k + k / 2));
			wr_reg(5'h07, 8'(8'h80 | sel));
			n = 0;
			while (req !== 1'b1 && n < 6000) begin
				@(negedge clk);
				n++;
			end
			// First tick may land anywhere inside one prescaler period
			chk("period in range", 16'h0001,
				16'(n >= t - p && n <= t + 4 + t / 64));
			chk("time base id", 16'h0005, {13'h0000, vid});
			wait_ack(n0);
			rchk(5'h01, 8'h00, "time base flag");
			rchk(5'h00, 8'h40, "global after tb");
			wr_reg(5'h07, 8'h00);
			ret_pulse();
		end
		$display("time base test done");
		give_verdict();
	end
endmodule : tb_top

`default_nettype wire
